// ==== dv/sfd_dma_model.sv ====
`timescale 1ns/1ps

module sfd_dma_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_dma_req,
    input wire logic tx_push_ready,
    output logic tx_push_valid,
    output logic [7:0] tx_push_data,
    input wire logic rx_dma_req,
    input wire logic rx_pop_avail,
    output logic rx_pop_req
);
    logic [7:0] cnt;

    // idle data line shows the inverse of the next byte, never the byte itself
    assign tx_push_data = tx_push_valid ? cnt : ~cnt;

    // one transfer every other cycle, so a dropped request is seen before the next one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_push_valid <= 1'b0;
            cnt <= 8'h00;
        end
        else
        begin
            tx_push_valid <= tx_dma_req && !(tx_push_valid && tx_push_ready);
            if (tx_push_valid && tx_push_ready)
                cnt <= cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_pop_req <= 1'b0;
        else
            rx_pop_req <= rx_dma_req && rx_pop_avail && !rx_pop_req;
    end
endmodule : sfd_dma_model

// ==== dv/test_spi_fifo_dma_request_control.sv ====
`timescale 1ns/1ps

module test_spi_fifo_dma_request_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h114a;
    logic pready, pslverr, err, tx_dma_req, rx_dma_req;
    logic tx_push_valid, tx_push_ready, tx_pop_req = 1'b0, tx_pop_avail, tx_pop_dv;
    logic rx_push_valid = 1'b0, rx_push_ready, rx_pop_req, rx_pop_avail, rx_pop_dv;
    logic [7:0] tx_push_data, tx_pop_data, rx_push_data = 8'h00, rx_pop_data, tx_n = 8'h00;
    sfd_pkg::sfd_flags_t evt_flags;
    sfd_pkg::sfd_flags_t evt_clr = '0;
    logic [7:0] tx_q[$], rx_q[$];
    int fails = 0, total_checks = 0;

    always #2.5 pclk = ~pclk;

    sfd_top i_sfd_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .tx_push_valid, .tx_push_data, .tx_push_ready, .tx_pop_req,
        .tx_pop_avail, .tx_pop_data, .tx_pop_dv, .rx_push_valid, .rx_push_data,
        .rx_push_ready, .rx_pop_req, .rx_pop_avail, .rx_pop_data, .rx_pop_dv, .tx_dma_req,
        .rx_dma_req, .evt_flags, .evt_clr);

    sfd_dma_model i_sfd_dma_model (.pclk, .presetn, .tx_dma_req, .tx_push_ready,
        .tx_push_valid, .tx_push_data, .rx_dma_req, .rx_pop_avail, .rx_pop_req);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // an empty queue is a mismatch, so an unknown byte never slips through
    task automatic chk_byte(input logic [7:0] got, ref logic [7:0] q[$], input string msg);
        if (q.size() == 0)
        begin
            total_checks++;
            fails++;
            $display("wrong value at %0t: %s with none expected", $time, msg);
        end
        else
            chk(got, q.pop_front(), msg);
    endtask : chk_byte

    task tmo(input string msg);
        fails++;
        $display("wrong value at %0t: timeout in %s", $time, msg);
        end_sim();
    endtask : tmo

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 16)
            tmo("apb");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [31:0] d);
        apb(1'b1, 12'h01c, d);
    endtask : wr

    task reg_chk(input logic [11:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, msg);
    endtask : reg_chk

    // waits until the dma partner has nothing left to move
    task settle;
        int n;
        for (n = 0; n < 64; n++)
        begin
            @(posedge pclk);
            if (tx_dma_req === 1'b0 && rx_dma_req === 1'b0 && tx_push_valid === 1'b0
                && rx_pop_req === 1'b0)
                break;
        end
        if (n == 64)
            tmo("settle");
    endtask : settle

    task tx_pop(input int cnt);
        int i, n;
        for (i = 0; i < cnt; i++)
        begin
            for (n = 0; n < 32; n++)
            begin
                @(posedge pclk);
                if (tx_pop_avail === 1'b1)
                    break;
            end
            if (n == 32)
                tmo("tx pop");
            tx_pop_req <= 1'b1;
            tx_q.push_back(tx_n);
            tx_n++;
            @(posedge pclk);
            tx_pop_req <= 1'b0;
        end
    endtask : tx_pop

    task rx_push(input int cnt);
        int i, n;
        for (i = 0; i < cnt; i++)
        begin
            @(posedge pclk);
            seed = lfsr(seed);
            rx_push_valid <= 1'b1;
            rx_push_data <= seed[7:0];
            for (n = 0; n < 32; n++)
            begin
                @(posedge pclk);
                if (rx_push_ready === 1'b1)
                    break;
            end
            if (n == 32)
                tmo("rx push");
            rx_q.push_back(seed[7:0]);
            rx_push_valid <= 1'b0;
            rx_push_data <= ~seed[7:0];
        end
    endtask : rx_push

    always @(posedge pclk)
    begin
        if (tx_pop_dv === 1'b1)
            chk_byte(tx_pop_data, tx_q, "tx byte");
        if (rx_pop_dv === 1'b1)
            chk_byte(rx_pop_data, rx_q, "rx byte");
    end

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        reg_chk(12'h01c, 32'h00000010, "reset ctrl");
        apb(1'b1, 12'h018, 32'hffffffff);
        chk(err, 1'b1, "unmapped write");
        reg_chk(12'h020, 32'h0, "unmapped read");
        chk(err, 1'b1, "unmapped read err");
        reg_chk(12'h01c, 32'h00000010, "ctrl kept");
        $display("test reset done");
        wr(32'h00008044);
        settle();
        reg_chk(12'h01c, 32'h00008444, "tx fill");
        chk(evt_flags.tx_thd, 1'b1, "tx flag");
        @(posedge pclk);
        evt_clr.tx_thd <= 1'b1;
        @(posedge pclk);
        evt_clr.tx_thd <= 1'b0;
        @(posedge pclk);
        chk(evt_flags.tx_thd, 1'b0, "tx flag clear");
        tx_pop(6);
        settle();
        reg_chk(12'h01c, 32'h00008444, "tx refill");
        wr(32'h00000044);
        tx_pop(2);
        chk(tx_dma_req, 1'b0, "tx dma off");
        reg_chk(12'h01c, 32'h00000244, "tx level");
        chk(evt_flags.tx_thd, 1'b1, "tx flag set");
        wr(32'h00000084);
        reg_chk(12'h01c, 32'h00000004, "tx flush");
        chk(evt_flags.tx_thd, 1'b0, "tx flush flag");
        wr(32'h00008004);
        @(posedge pclk);
        chk(tx_dma_req, 1'b0, "disabled fifo dma");
        chk({tx_push_ready, rx_push_ready}, 2'b00, "disabled push");
        chk({tx_pop_avail, rx_pop_avail}, 2'b00, "disabled pop");
        $display("test tx done");
        wr(32'h00420000);
        rx_push(3);
        reg_chk(12'h01c, 32'h03420000, "rx level");
        chk(evt_flags.rx_thd, 1'b1, "rx flag");
        chk(rx_dma_req, 1'b0, "rx dma gated");
        @(posedge pclk);
        evt_clr.rx_thd <= 1'b1;
        @(posedge pclk);
        evt_clr.rx_thd <= 1'b0;
        @(posedge pclk);
        chk(evt_flags.rx_thd, 1'b0, "rx flag clear");
        wr(32'h00420000);
        reg_chk(12'h01c, 32'h03420000, "rx zero flush");
        wr(32'h80420000);
        settle();
        reg_chk(12'h01c, 32'h82420000, "rx drained");
        wr(32'h00420000);
        rx_push(2);
        chk(rx_dma_req, 1'b0, "rx dma off");
        reg_chk(12'h01c, 32'h04420000, "rx level 4");
        wr(32'h00c20000);
        reg_chk(12'h01c, 32'h00420000, "rx flush");
        chk(evt_flags.rx_thd, 1'b0, "rx flush flag");
        rx_q.delete();
        wr(32'h80400000);
        rx_push(8);
        settle();
        reg_chk(12'h01c, 32'h80400000, "rx empty");
        chk(rx_q.size(), 32'h0, "rx all moved");
        $display("test rx done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        reg_chk(12'h01c, 32'h00000010, "ctrl after reset");
        chk(evt_flags, 2'b00, "flags after reset");
        $display("test second reset done");
        end_sim();
    end
endmodule : test_spi_fifo_dma_request_control

// ==== rtl/sfd_consts.svh ====
`ifndef SFD_CONSTS_SVH
`define SFD_CONSTS_SVH

`define SFD_ADDR_W 12
`define SFD_CTRL_ADDR 12'h01c
`define SFD_DMA_RX_EN_BIT 31
`define SFD_RX_LVL_HI 30
`define SFD_RX_LVL_LO 24
`define SFD_RX_FLUSH_BIT 23
`define SFD_RX_FIFO_EN_BIT 22
`define SFD_RX_THD_HI 20
`define SFD_RX_THD_LO 16
`define SFD_DMA_TX_EN_BIT 15
`define SFD_TX_LVL_HI 14
`define SFD_TX_LVL_LO 8
`define SFD_TX_FLUSH_BIT 7
`define SFD_TX_FIFO_EN_BIT 6
`define SFD_TX_THD_HI 4
`define SFD_TX_THD_LO 0
`define SFD_THD_W 5
`define SFD_LVL_W 7
`define SFD_TX_THD_RESET 5'h10
`define SFD_RX_THD_RESET 5'h00
`define SFD_FIFO_DEPTH 32
`define SFD_DATA_W 8

`endif

// ==== rtl/sfd_pkg.sv ====
`include "sfd_consts.svh"

package sfd_pkg;

    typedef struct packed {
        logic dma_rx_en;
        logic rx_fifo_en;
        logic [`SFD_THD_W-1:0] rx_thd;
        logic dma_tx_en;
        logic tx_fifo_en;
        logic [`SFD_THD_W-1:0] tx_thd;
    } sfd_ctrl_t;

    // spi_event_flags threshold bits owned by this block
    typedef struct packed {
        logic rx_thd;
        logic tx_thd;
    } sfd_flags_t;

endpackage : sfd_pkg

// ==== rtl/sfd_ram.sv ====
`timescale 1ns/1ps

module sfd_ram #(
    parameter int DW = 8,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem [1<<AW];

    // no reset on the array, it maps onto plain ram
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : sfd_ram

// ==== rtl/sfd_top.sv ====
// Functional notes
// RQ1 - Clearing the receive DMA enable drops and cancels the receive DMA request at once.
// RQ2 - The receive level field reads the live byte count of the receive FIFO and is read-only.
// RQ3 - Writing one to receive flush empties the receive FIFO and clears its flags; zero does nothing. Here a crossing in the flush cycle sets the flag.
// RQ4 - Software should flush the receive FIFO only while it is not receiving data.
// RQ5 - Receive level above the receive threshold sets its flag and, if enabled, a DMA request.
// RQ6 - Software programs the receive threshold only from zero to thirty.
// RQ7 - The transmit DMA enable bit enables transmit requests; clearing it cancels a pending one.
// RQ8 - The read-only transmit level field returns the byte count of the transmit FIFO.
// RQ9 - Writing one to transmit flush empties the transmit FIFO and clears its flags; zero does nothing. Here a crossing in the flush cycle sets the flag.
// RQ10 - Software should clear the transmit FIFO enable before a transmit flush.
// RQ11 - Transmit level below the transmit threshold sets its flag and, if enabled, a DMA request.
// RQ12 - After reset the transmit threshold holds sixteen and all other control fields are zero.
// RQ13 - A disabled FIFO neither accepts nor supplies data and raises no threshold events or requests.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "sfd_consts.svh"

module sfd_top #(
    parameter int DEPTH = `SFD_FIFO_DEPTH,
    parameter int DW = `SFD_DATA_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SFD_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_push_valid,
    input wire logic [DW-1:0] tx_push_data,
    output logic tx_push_ready,
    input wire logic tx_pop_req,
    output logic tx_pop_avail,
    output logic [DW-1:0] tx_pop_data,
    output logic tx_pop_dv,
    input wire logic rx_push_valid,
    input wire logic [DW-1:0] rx_push_data,
    output logic rx_push_ready,
    input wire logic rx_pop_req,
    output logic rx_pop_avail,
    output logic [DW-1:0] rx_pop_data,
    output logic rx_pop_dv,
    output logic tx_dma_req,
    output logic rx_dma_req,
    output sfd_pkg::sfd_flags_t evt_flags,
    input wire sfd_pkg::sfd_flags_t evt_clr
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int TX = 0;
    localparam int RX = 1;

    // spi_fifo_dma_control register image
    sfd_pkg::sfd_ctrl_t ctrl;
    logic [1:0] fifo_en;
    logic [1:0] flush;
    logic [1:0] push_v;
    logic [1:0] pop_r;
    logic [1:0] push_ok;
    logic [1:0] pop_ok;
    logic [1:0] cond;
    logic [1:0] cond_q;
    logic [1:0] rise;
    logic [1:0] flags;
    logic [1:0] clr;
    logic [1:0] pop_dv;
    logic [DW-1:0] push_d [2];
    logic [DW-1:0] rd_d [2];
    logic [AW-1:0] wp [2];
    logic [AW-1:0] rp [2];
    logic [CW-1:0] cnt [2];
    logic [31:0] rd_word;
    logic setup;
    logic access;
    logic hit;
    logic wr;

    function automatic logic [`SFD_LVL_W-1:0] lvl_of(input logic [CW-1:0] c);
        lvl_of = `SFD_LVL_W'(c);
    endfunction : lvl_of

    // apb slave: zero wait states, unmapped addresses answer with an error
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign hit = (paddr == `SFD_CTRL_ADDR);
    assign wr = access & pwrite & hit;
    assign pready = 1'b1;
    assign pslverr = access & ~hit;

    always_comb
    begin
        rd_word = '0;
        rd_word[`SFD_DMA_RX_EN_BIT] = ctrl.dma_rx_en;
        rd_word[`SFD_RX_LVL_HI:`SFD_RX_LVL_LO] = lvl_of(cnt[RX]); // [RQ2]
        rd_word[`SFD_RX_FIFO_EN_BIT] = ctrl.rx_fifo_en;
        rd_word[`SFD_RX_THD_HI:`SFD_RX_THD_LO] = ctrl.rx_thd;
        rd_word[`SFD_DMA_TX_EN_BIT] = ctrl.dma_tx_en;
        rd_word[`SFD_TX_LVL_HI:`SFD_TX_LVL_LO] = lvl_of(cnt[TX]); // [RQ8]
        rd_word[`SFD_TX_FIFO_EN_BIT] = ctrl.tx_fifo_en;
        rd_word[`SFD_TX_THD_HI:`SFD_TX_THD_LO] = ctrl.tx_thd;
    end

    // captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
        end
        else if (setup)
        begin
            prdata <= (hit && !pwrite) ? rd_word : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl.dma_rx_en <= 1'b0;
            ctrl.rx_fifo_en <= 1'b0;
            ctrl.rx_thd <= `SFD_RX_THD_RESET;
            ctrl.dma_tx_en <= 1'b0;
            ctrl.tx_fifo_en <= 1'b0;
            ctrl.tx_thd <= `SFD_TX_THD_RESET; // [RQ12]
        end
        else if (wr)
        begin
            ctrl.dma_rx_en <= pwdata[`SFD_DMA_RX_EN_BIT];
            ctrl.rx_fifo_en <= pwdata[`SFD_RX_FIFO_EN_BIT];
            // an all-ones receive threshold is stored as written
            ctrl.rx_thd <= pwdata[`SFD_RX_THD_HI:`SFD_RX_THD_LO];
            ctrl.dma_tx_en <= pwdata[`SFD_DMA_TX_EN_BIT];
            ctrl.tx_fifo_en <= pwdata[`SFD_TX_FIFO_EN_BIT];
            ctrl.tx_thd <= pwdata[`SFD_TX_THD_HI:`SFD_TX_THD_LO];
        end
    end

    // flush bits act only on a written one and never read back
    assign flush[RX] = wr & pwdata[`SFD_RX_FLUSH_BIT]; // [RQ3]
    assign flush[TX] = wr & pwdata[`SFD_TX_FLUSH_BIT]; // [RQ9]

    assign fifo_en[TX] = ctrl.tx_fifo_en;
    assign fifo_en[RX] = ctrl.rx_fifo_en;
    assign push_v[TX] = tx_push_valid;
    assign push_v[RX] = rx_push_valid;
    assign pop_r[TX] = tx_pop_req;
    assign pop_r[RX] = rx_pop_req;
    assign push_d[TX] = tx_push_data;
    assign push_d[RX] = rx_push_data;
    assign clr[TX] = evt_clr.tx_thd;
    assign clr[RX] = evt_clr.rx_thd;

    // a flush in the same cycle refuses the push rather than losing it silently
    always_comb
    begin
        for (int d = 0; d < 2; d++)
        begin
            push_ok[d] = fifo_en[d] & ~flush[d] & (cnt[d] != CW'(DEPTH)); // [RQ13]
            push_ok[d] = push_ok[d] & push_v[d];
            pop_ok[d] = fifo_en[d] & ~flush[d] & (cnt[d] != '0) & pop_r[d]; // [RQ13]
        end
    end

    assign tx_push_ready = fifo_en[TX] & ~flush[TX] & (cnt[TX] != CW'(DEPTH));
    assign rx_push_ready = fifo_en[RX] & ~flush[RX] & (cnt[RX] != CW'(DEPTH));
    assign tx_pop_avail = fifo_en[TX] & (cnt[TX] != '0);
    assign rx_pop_avail = fifo_en[RX] & (cnt[RX] != '0);

    // pointers wrap naturally, so DEPTH must be a power of two
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int d = 0; d < 2; d++)
            begin
                wp[d] <= '0;
                rp[d] <= '0;
                cnt[d] <= '0;
            end
        end
        else
        begin
            for (int d = 0; d < 2; d++)
            begin
                if (flush[d])
                begin
                    wp[d] <= '0; // [RQ3] [RQ9]
                    rp[d] <= '0;
                    cnt[d] <= '0;
                end
                else
                begin
                    wp[d] <= wp[d] + AW'(push_ok[d]);
                    rp[d] <= rp[d] + AW'(pop_ok[d]);
                    cnt[d] <= cnt[d] + CW'(push_ok[d]) - CW'(pop_ok[d]);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pop_dv <= '0;
        end
        else
        begin
            pop_dv <= pop_ok;
        end
    end

    for (genvar g = 0; g < 2; g++)
    begin : g_ram
        sfd_ram #(
            .DW(DW),
            .AW(AW)
        ) u_ram (
            .clk(pclk),
            .wr_en(push_ok[g]),
            .wr_addr(wp[g]),
            .wr_data(push_d[g]),
            .rd_en(pop_ok[g]),
            .rd_addr(rp[g]),
            .rd_data(rd_d[g])
        );
    end

    assign tx_pop_data = rd_d[TX];
    assign rx_pop_data = rd_d[RX];
    assign tx_pop_dv = pop_dv[TX];
    assign rx_pop_dv = pop_dv[RX];

    // threshold conditions, held off while the fifo is disabled
    assign cond[RX] = fifo_en[RX] &
        (lvl_of(cnt[RX]) > `SFD_LVL_W'(ctrl.rx_thd)); // [RQ5] [RQ13]
    assign cond[TX] = fifo_en[TX] &
        (lvl_of(cnt[TX]) < `SFD_LVL_W'(ctrl.tx_thd)); // [RQ11] [RQ13]
    assign rise = cond & ~cond_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cond_q <= '0;
        end
        else
        begin
            cond_q <= cond;
        end
    end

    // a crossing in the clearing cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags <= '0;
        end
        else
        begin
            for (int d = 0; d < 2; d++)
            begin
                if (rise[d])
                begin
                    flags[d] <= 1'b1; // [RQ5] [RQ11]
                end
                else if (flush[d] || clr[d])
                begin
                    flags[d] <= 1'b0; // [RQ3] [RQ9]
                end
            end
        end
    end

    assign evt_flags.rx_thd = flags[RX];
    assign evt_flags.tx_thd = flags[TX];

    // level requests: dropping the enable cancels a pending one the same cycle
    assign rx_dma_req = ctrl.dma_rx_en & cond[RX]; // [RQ1] [RQ5]
    assign tx_dma_req = ctrl.dma_tx_en & cond[TX]; // [RQ7] [RQ11]

    logic seen_wr;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seen_wr <= 1'b0;
        end
        else if (wr)
        begin
            seen_wr <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence rx_read_s;
        setup && hit && !pwrite;
    endsequence
    sequence rx_cross_s;
        !cond[RX] ##1 cond[RX];
    endsequence
    sequence tx_cross_s;
        !cond[TX] ##1 cond[TX];
    endsequence

    rx_dma_cancel_a: assert property ($fell(ctrl.dma_rx_en) |-> !rx_dma_req) // [RQ1]
        else $error("rx dma request survived disable");
    rx_level_read_a: assert property (rx_read_s |=> // [RQ2]
        prdata[`SFD_RX_LVL_HI:`SFD_RX_LVL_LO] == lvl_of($past(cnt[RX])))
        else $error("rx level readback wrong");
    rx_flush_a: assert property (flush[RX] && !rise[RX] |=> cnt[RX] == '0 && !flags[RX]) // [RQ3]
        else $error("rx flush did not empty fifo");
    rx_thd_flag_a: assert property (rx_cross_s |=> flags[RX]) // [RQ5]
        else $error("rx threshold flag not set");
    rx_dma_level_a: assert property (rx_dma_req |->
        fifo_en[RX] && lvl_of(cnt[RX]) > `SFD_LVL_W'(ctrl.rx_thd)) // [RQ5]
        else $error("rx dma request without level");
    tx_dma_enable_a: assert property ($rose(ctrl.dma_tx_en) && cond[TX] |-> tx_dma_req) // [RQ7]
        else $error("tx dma request missing");
    tx_level_read_a: assert property (rx_read_s |=> // [RQ8]
        prdata[`SFD_TX_LVL_HI:`SFD_TX_LVL_LO] == lvl_of($past(cnt[TX])))
        else $error("tx level readback wrong");
    tx_flush_a: assert property (flush[TX] |=> cnt[TX] == '0 ##1 lvl_of(cnt[TX]) < 2) // [RQ9]
        else $error("tx flush did not empty fifo");
    tx_thd_flag_a: assert property (tx_cross_s |=> flags[TX]) // [RQ11]
        else $error("tx threshold flag not set");
    thd_reset_a: assert property (!seen_wr |-> ctrl.tx_thd == `SFD_TX_THD_RESET) // [RQ12]
        else $error("tx threshold reset value wrong");
    fifo_gate_a: assert property (!fifo_en[TX] |-> !tx_push_ready && !tx_dma_req) // [RQ13]
        else $error("disabled tx fifo active");

endmodule : sfd_top
